// [inc/bcme_cfg.svh]
// Offsets, field positions, codes and reset values of the big-number engine.
`ifndef BCME_CFG_SVH
`define BCME_CFG_SVH
// ==========================================
// Geometry
`define BCME_AW         10
`define BCME_RAM_BYTES  17'h01000
`define BCME_LEN_MIN    12'h004
`define BCME_LEN_MAX    12'hFFC
`define BCME_RST_WORD   32'h00000000
// ==========================================
// Register offsets (byte address bits 11:0, RAM window when bit 12 is set)
`define BCME_RAM_BIT    12
`define BCME_OFS_CTRL   12'h000
`define BCME_OFS_STAT   12'h004
`define BCME_OFS_SRC    12'h008
`define BCME_OFS_RES    12'h00C
`define BCME_OFS_SLEN   12'h010
`define BCME_OFS_RLEN   12'h014
`define BCME_OFS_ACC    12'h018
`define BCME_OFS_MUL    12'h01C
`define BCME_OFS_MODP   12'h020
`define BCME_OFS_MODL   12'h024
`define BCME_OFS_CNS    12'h028
`define BCME_OFS_CAR    12'h02C
// ==========================================
// Control fields
`define BCME_C_START    0
`define BCME_C_SVC      2:1
`define BCME_C_COND     4:3
`define BCME_C_CIN      5
`define BCME_C_SUB      6
`define BCME_C_ACC      7
`define BCME_C_MOD      8
`define BCME_C_GF       9
`define BCME_C_OP       11:10
// ==========================================
// Codes
`define BCME_SVC_MOVE   2'h0
`define BCME_SVC_COND   2'h1
`define BCME_SVC_MUL    2'h2
`define BCME_SVC_MOD    2'h3
`define BCME_OP_CNS     2'h0
`define BCME_OP_RED     2'h1
`define BCME_OP_NORM    2'h2
`define BCME_CND_ALWAYS 2'h0
`define BCME_CND_NEVER  2'h1
`define BCME_CND_CIN    2'h2
`define BCME_CND_NCIN   2'h3
`define BCME_ST_OK      8'h00
`define BCME_ST_BAD     8'h01
`define BCME_ST_NOSETUP 8'h02
`endif

// [inc/bcme_pkg.sv]
// Types of the big-number engine.
`default_nettype none
`include "bcme_cfg.svh"
package bcme_pkg;
	typedef enum logic [2:0] {S_IDLE, S_CHK, S_COPY, S_MUL, S_CMP, S_SUB, S_QLO, S_QHI} bcme_state_t;
	typedef struct packed {
		bcme_state_t            st;
		logic [`BCME_AW-1:0]    idx;
		logic [31:0]            mcar;
		logic                   acar;
		logic [63:0]            quo;
		logic [7:0]             code;
		logic                   setup;
		logic [11:0]            ctrl;
		logic [15:0]            src;
		logic [15:0]            res;
		logic [15:0]            acc;
		logic [15:0]            modp;
		logic [15:0]            cns;
		logic [11:0]            slen;
		logic [11:0]            rlen;
		logic [11:0]            modl;
		logic [31:0]            mul;
		logic [31:0]            carop;
		logic [31:0]            rdata;
		logic                   err;
	} bcme_s_t;
endpackage
`default_nettype wire

// [rtl/bcme_ram.sv]
// Crypto RAM: flip-flop words, two read ports and one write port.
`default_nettype none
module bcme_ram #(
	parameter int AW = 10
) (
	// Clock
	input  wire logic          clk,
	// Write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [31:0]   wdata,
	// Read ports
	input  wire logic [AW-1:0] raddr_a,
	input  wire logic [AW-1:0] raddr_b,
	output logic [31:0]        rdata_a,
	output logic [31:0]        rdata_b
);
	// ==========================================
	// Storage
	// Data words carry no reset; software loads them before use.
	logic [31:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	assign rdata_a = mem[raddr_a];
	assign rdata_b = mem[raddr_b];
endmodule
`default_nettype wire

// [rtl/bcme_top.sv]
// Big-number copy, multiply and reduction engine behind an APB slave.
//
// The implementer's own choices: register access over APB and the address map.
`default_nettype none
`include "bcme_cfg.svh"
module bcme_top
	import bcme_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [12:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic             PREADY,
	output logic [31:0]      PRDATA,
	output logic             PSLVERR
);
	localparam int AW = `BCME_AW;

	// ==========================================
	// Helpers
	function automatic logic [AW-1:0] wa(input logic [15:0] p, input logic [AW-1:0] i);
		wa = p[AW+1:2] + i;
	endfunction

	function automatic logic [AW-1:0] words(input logic [11:0] len);
		words = len[AW+1:2];
	endfunction

	function automatic logic area_ok(input logic [15:0] p, input logic [11:0] len);
		area_ok = (p[1:0] == 2'h0) && (len[1:0] == 2'h0) && (len >= `BCME_LEN_MIN) &&
			(len <= `BCME_LEN_MAX) && (({1'b0, p} + {5'h00, len}) <= `BCME_RAM_BYTES);
	endfunction

	function automatic logic [63:0] clmul(input logic [31:0] a, input logic [31:0] b);
		logic [63:0] acc;
		acc = 64'h0;
		for (int k = 0; k < 32; k++) begin
			if (b[k]) begin
				acc = acc ^ ({32'h0, a} << k);
			end
		end
		clmul = acc;
	endfunction

	// ==========================================
	// State
	bcme_s_t r;
	bcme_s_t next_r;

	logic [31:0]   rda;
	logic [31:0]   rdb;
	logic [AW-1:0] ra;
	logic [AW-1:0] rb;
	logic          we;
	logic [AW-1:0] waddr;
	logic [31:0]   wd;
	logic [1:0]    svc;
	logic          cg;
	logic          red;
	logic [15:0]   pa;
	logic [15:0]   pb;
	logic [15:0]   pw;
	logic [AW-1:0] na;
	logic [AW-1:0] nb;
	logic [AW-1:0] nw;
	logic [31:0]   xa;
	logic [31:0]   xb;
	logic [63:0]   prod;
	logic [31:0]   opl;
	logic [31:0]   opr;
	logic [32:0]   arith;
	logic [32:0]   bor;
	logic          last;
	logic          busy;
	logic          cond_ok;
	logic          src_ok;
	logic          res_ok;
	logic          setup_ph;
	logic          acc_ph;
	logic          ram_hit;
	logic [31:0]   reg_rd;
	logic          reg_hit;

	bcme_ram #(.AW(AW)) u_ram (
		.clk     (CLK),
		.we      (we),
		.waddr   (waddr),
		.wdata   (wd),
		.raddr_a (ra),
		.raddr_b (rb),
		.rdata_a (rda),
		.rdata_b (rdb)
	);

	// ==========================================
	// Datapath
	always_comb begin
		svc  = r.ctrl[`BCME_C_SVC];
		busy = (r.st != S_IDLE);
		red  = (r.st == S_CMP) || (r.st == S_SUB);
		cg   = (svc == `BCME_SVC_MOD) && (r.ctrl[`BCME_C_OP] == `BCME_OP_CNS);
		pa   = red ? r.res : (cg ? r.modp : r.src);
		pb   = red ? r.modp : r.acc;
		pw   = cg ? r.cns : r.res;
		nb   = words(r.modl + 12'h004);
		// A zero source pointer reads as an all-zero source of no length.
		na   = cg ? nb : ((r.src == 16'h0000) ? '0 : words(r.slen));
		if (red) begin
			nw = (words(r.rlen) > nb) ? words(r.rlen) : nb;
		end else if (cg) begin
			nw = words(r.modl + 12'h008);
		end else begin
			nw = words(r.rlen);
		end
		last = (r.idx == nw - 1'b1);
		xa   = (red || r.idx < na) ? rda : 32'h00000000;
		if (red) begin
			xb = (r.idx < nb) ? rdb : 32'h00000000;
		end else begin
			xb = r.ctrl[`BCME_C_ACC] ? rdb : 32'h00000000;
		end
		if (r.ctrl[`BCME_C_GF]) begin
			prod = clmul(r.mul, xa) ^ {32'h0, r.mcar};
		end else begin
			prod = {32'h0, r.mul} * {32'h0, xa} + {32'h0, r.mcar};
		end
		opl = red ? xa : xb;
		opr = red ? xb : prod[31:0];
		if (r.ctrl[`BCME_C_GF]) begin
			arith = {1'b0, opl ^ opr};
		end else if (red || r.ctrl[`BCME_C_SUB]) begin
			arith = {1'b0, opl} - {1'b0, opr} - {32'h0, r.acar};
		end else begin
			arith = {1'b0, opl} + {1'b0, opr} + {32'h0, r.acar};
		end
		// Magnitude test stays integer in both fields; polynomial mode swaps the add, the subtract and the product.
		bor = {1'b0, xa} - {1'b0, xb} - {32'h0, r.acar};
		case (r.ctrl[`BCME_C_COND])
			`BCME_CND_ALWAYS: cond_ok = 1'b1;
			`BCME_CND_NEVER:  cond_ok = 1'b0;
			`BCME_CND_CIN:    cond_ok = r.ctrl[`BCME_C_CIN];
			default:          cond_ok = !r.ctrl[`BCME_C_CIN];
		endcase
		res_ok = area_ok(r.res, r.rlen);
		src_ok = (r.src == 16'h0000) || (area_ok(r.src, r.slen) && (r.slen <= r.rlen) &&
			!((r.src < r.res + {4'h0, r.rlen}) && (r.res < r.src + {4'h0, r.slen})));
	end

	// ==========================================
	// Bus decode
	always_comb begin
		setup_ph = PSEL && !PENABLE;
		acc_ph   = PSEL && PENABLE;
		ram_hit  = PADDR[`BCME_RAM_BIT];
		reg_hit  = 1'b1;
		case (PADDR[11:0])
			`BCME_OFS_CTRL: reg_rd = {20'h0, r.ctrl};
			`BCME_OFS_STAT: reg_rd = {15'h0, r.setup, r.code, 7'h0, busy};
			`BCME_OFS_SRC:  reg_rd = {16'h0, r.src};
			`BCME_OFS_RES:  reg_rd = {16'h0, r.res};
			`BCME_OFS_SLEN: reg_rd = {20'h0, r.slen};
			`BCME_OFS_RLEN: reg_rd = {20'h0, r.rlen};
			`BCME_OFS_ACC:  reg_rd = {16'h0, r.acc};
			`BCME_OFS_MUL:  reg_rd = r.mul;
			`BCME_OFS_MODP: reg_rd = {16'h0, r.modp};
			`BCME_OFS_MODL: reg_rd = {20'h0, r.modl};
			`BCME_OFS_CNS:  reg_rd = {16'h0, r.cns};
			`BCME_OFS_CAR:  reg_rd = r.carop;
			default: begin
				reg_rd  = `BCME_RST_WORD;
				reg_hit = 1'b0;
			end
		endcase
		ra = busy ? wa(pa, r.idx) : PADDR[AW+1:2];
		rb = wa(pb, r.idx);
	end

	// ==========================================
	// Next state
	always_comb begin
		next_r = r;
		we     = 1'b0;
		waddr  = wa(pw, r.idx);
		wd     = xa;
		if (setup_ph) begin
			next_r.rdata = ram_hit ? rda : reg_rd;
			// The RAM window is closed while a service owns it.
			next_r.err   = ram_hit ? busy : !reg_hit;
		end
		if (acc_ph && PWRITE && !r.err) begin
			if (ram_hit) begin
				we    = 1'b1;
				waddr = PADDR[AW+1:2];
				wd    = PWDATA;
			end else if (!busy) begin
				case (PADDR[11:0])
					`BCME_OFS_CTRL: begin
						next_r.ctrl = {PWDATA[11:1], 1'b0};
						if (PWDATA[`BCME_C_START]) begin
							next_r.st = S_CHK;
						end
					end
					`BCME_OFS_SRC:  next_r.src   = PWDATA[15:0];
					`BCME_OFS_RES:  next_r.res   = PWDATA[15:0];
					`BCME_OFS_SLEN: next_r.slen  = PWDATA[11:0];
					`BCME_OFS_RLEN: next_r.rlen  = PWDATA[11:0];
					`BCME_OFS_ACC:  next_r.acc   = PWDATA[15:0];
					`BCME_OFS_MUL:  next_r.mul   = PWDATA;
					`BCME_OFS_MODP: next_r.modp  = PWDATA[15:0];
					`BCME_OFS_MODL: next_r.modl  = PWDATA[11:0];
					`BCME_OFS_CNS:  next_r.cns   = PWDATA[15:0];
					`BCME_OFS_CAR:  next_r.carop = PWDATA;
					default: begin
					end
				endcase
			end
		end
		case (r.st)
			S_IDLE: begin
			end
			S_CHK: begin
				next_r.idx  = '0;
				next_r.mcar = r.carop;
				next_r.acar = 1'b0;
				next_r.quo  = 64'h0;
				next_r.code = `BCME_ST_OK;
				next_r.st   = S_IDLE;
				if (svc == `BCME_SVC_MOD) begin
					if (cg) begin
						next_r.st = S_COPY;
					end else if (r.ctrl[`BCME_C_OP] == `BCME_OP_NORM && !r.setup) begin
						next_r.code = `BCME_ST_NOSETUP;
					end else if (r.ctrl[`BCME_C_OP] != `BCME_OP_CNS && r.ctrl[`BCME_C_OP] <= `BCME_OP_NORM
						&& res_ok) begin
						next_r.st = S_CMP;
					end else begin
						next_r.code = `BCME_ST_BAD;
					end
				end else if (!(src_ok && res_ok)) begin
					next_r.code = `BCME_ST_BAD;
				end else if (svc == `BCME_SVC_MUL) begin
					next_r.st = S_MUL;
				end else if (svc == `BCME_SVC_MOVE || cond_ok) begin
					next_r.st = S_COPY;
				end
			end
			S_COPY: begin
				we = 1'b1;
				if (last) begin
					next_r.st    = S_IDLE;
					next_r.setup = r.setup || cg;
				end else begin
					next_r.idx = r.idx + 1'b1;
				end
			end
			S_MUL: begin
				we          = 1'b1;
				wd          = arith[31:0];
				next_r.mcar = prod[63:32];
				next_r.acar = arith[32];
				next_r.idx  = r.idx + 1'b1;
				if (last) begin
					next_r.idx  = '0;
					next_r.acar = 1'b0;
					next_r.st   = r.ctrl[`BCME_C_MOD] ? S_CMP : S_IDLE;
				end
			end
			S_CMP: begin
				next_r.acar = bor[32];
				next_r.idx  = r.idx + 1'b1;
				if (last) begin
					next_r.idx  = '0;
					next_r.acar = 1'b0;
					next_r.st   = bor[32] ? S_QLO : S_SUB;
				end
			end
			S_SUB: begin
				we          = (r.idx < words(r.rlen));
				wd          = arith[31:0];
				next_r.acar = bor[32];
				next_r.idx  = r.idx + 1'b1;
				if (last) begin
					next_r.idx  = '0;
					next_r.acar = 1'b0;
					next_r.quo  = r.quo + 64'h1;
					next_r.st   = S_CMP;
				end
			end
			S_QLO: begin
				we        = 1'b1;
				waddr     = wa(r.res, words(r.rlen));
				wd        = r.quo[31:0];
				next_r.st = S_QHI;
			end
			S_QHI: begin
				we        = 1'b1;
				waddr     = wa(r.res, words(r.rlen) + 1'b1);
				wd        = r.quo[63:32];
				next_r.st = S_IDLE;
			end
			default: next_r.st = S_IDLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign PREADY  = 1'b1;
	assign PRDATA  = r.rdata;
	assign PSLVERR = acc_ph && r.err;

	// ==========================================
	// Checks
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	a_zero_src_skip: assert property ((r.st == S_CHK) && (r.src == 16'h0000) && res_ok &&
		((svc == `BCME_SVC_MOVE) || ((svc == `BCME_SVC_COND) && cond_ok)) |=> (r.st == S_COPY))
		else $error("zero source pointer was checked");
	a_cond_false_quiet: assert property ((r.st == S_CHK) && (svc == `BCME_SVC_COND) && !cond_ok
		|-> ##1 (!we && r.st == S_IDLE) ##1 (r.code == `BCME_ST_OK))
		else $error("false condition touched memory");
	a_copy_low_words: assert property ((r.st == S_COPY) && (r.idx < na) |-> we && (wd == rda))
		else $error("copy word differs from source");
	a_pad_high_zero: assert property ((r.st == S_COPY) && (r.idx >= na) |-> we && (wd == 32'h00000000))
		else $error("padding word not zero");
	a_mul_span_len: assert property ((r.st == S_MUL) && last && !r.ctrl[`BCME_C_MOD]
		|-> we && (waddr == wa(r.res, words(r.rlen) - 1'b1)) ##1 (r.st == S_IDLE))
		else $error("multiply wrote past result length");
	a_mul_first_word: assert property ((r.st == S_MUL) && (r.idx == '0) && !r.ctrl[`BCME_C_ACC] &&
		!r.ctrl[`BCME_C_SUB] && !r.ctrl[`BCME_C_GF] |-> (wd == r.mul * xa + r.carop))
		else $error("multiply word wrong");
	a_quo_above_num: assert property ((r.st == S_QLO) |-> we && (waddr == wa(r.res, words(r.rlen)))
		##1 (r.st == S_QHI) && we && (wd == r.quo[63:32]))
		else $error("quotient not stored above number");
	a_norm_needs_cns: assert property ((r.st == S_CHK) && (svc == `BCME_SVC_MOD) &&
		(r.ctrl[`BCME_C_OP] == `BCME_OP_NORM) && !r.setup |=> (r.code == `BCME_ST_NOSETUP) && !busy)
		else $error("normalize ran without constant");
	a_norm_one_step: assert property ((r.st == S_CHK) && (svc == `BCME_SVC_MOD) && r.setup && res_ok &&
		(r.ctrl[`BCME_C_OP] != `BCME_OP_CNS) && (r.ctrl[`BCME_C_OP] <= `BCME_OP_NORM) |=> (r.st == S_CMP))
		else $error("reduction step skipped");
	a_gf_sub_xor: assert property ((r.st == S_SUB) && r.ctrl[`BCME_C_GF] && we |-> (wd == (rda ^ xb)))
		else $error("polynomial subtract not xor");
	a_done_ok_code: assert property ($past(r.st) == S_QHI && (r.st == S_IDLE) |-> (r.code == `BCME_ST_OK))
		else $error("status not success after reduction");
endmodule
`default_nettype wire

// [verif/bcme_host.sv]
// Host firmware model: an APB master that issues service calls to the engine.
`default_nettype none
module bcme_host (
	// Clock
	input  wire logic        clk,
	// APB master side
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [12:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Idle bus
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 13'h0000;
		pwdata = 32'h00000000;
	end
	// ==========================================
	// One transfer
	// Pointers and lengths handed in by callers go out as given, aligned or not, with no range check.
	// The multiplier is always a word value in its own register, never a pointer.
	task automatic xfer(input logic wr, input logic [12:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// Only the bench watchdog ends a wait that never sees ready.
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		// Address and write data are inverted on release so a stale value is never mistaken for a fresh one.
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~wd;
	endtask
endmodule
`default_nettype wire

// [verif/bignum_copy_multiply_engine_test.sv]
// Self-checking testbench of the big-number engine.
`default_nettype none
`include "bcme_cfg.svh"
module bignum_copy_multiply_engine_test;
	import bcme_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLK = 1'b0;
	logic        SYS_RST = 1'b1;
	logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [12:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	int          miscompares = 0;
	int          n_tests = 0;
	logic        tk;
	always #5 CLK = ~CLK;
	bcme_top u_dut (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR));
	bcme_host u_host (.clk(CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
		.pwdata(PWDATA), .pready(PREADY), .prdata(PRDATA), .pslverr(PSLVERR));
	// ==========================================
	// Helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [12:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		u_host.xfer(1'b1, a, d, r, e);
	endtask
	task automatic rc(input string what, input logic [12:0] a, input logic [31:0] exp, input logic experr);
		logic [31:0] r;
		logic        e;
		u_host.xfer(1'b0, a, 32'h00000000, r, e);
		chk(what, exp, r);
		chk({what, " error"}, {31'h0, experr}, {31'h0, e});
	endtask
	function automatic logic [12:0] ram(input logic [11:0] p);
		return {1'b1, p};
	endfunction
	function automatic logic [11:0] cw(input logic [1:0] svc, input logic [1:0] cnd, input logic cin,
		input logic sub, input logic acc, input logic [1:0] op);
		return {op, 1'b0, 1'b0, acc, sub, cin, cnd, svc, 1'b1};
	endfunction
	task automatic setp(input logic [15:0] s, input logic [15:0] r, input logic [11:0] sl, input logic [11:0] rl);
		wr(`BCME_OFS_SRC, {16'h0, s});
		wr(`BCME_OFS_RES, {16'h0, r});
		wr(`BCME_OFS_SLEN, {20'h0, sl});
		wr(`BCME_OFS_RLEN, {20'h0, rl});
	endtask
	task automatic run(input logic [11:0] c, input logic [7:0] code);
		logic [31:0] s;
		logic        e;
		int          n;
		wr(`BCME_OFS_CTRL, {20'h0, c});
		n = 0;
		do begin
			u_host.xfer(1'b0, `BCME_OFS_STAT, 32'h0, s, e);
			n++;
		end while (s[0] !== 1'b0 && n < 3000);
		chk("service done", 32'h0, {31'h0, s[0]});
		chk("status code", {24'h0, code}, {24'h0, s[15:8]});
	endtask
	task automatic fill4(input logic [11:0] p, input logic [31:0] v);
		for (int i = 0; i < 4; i++) wr(ram(p + 12'(4 * i)), v);
	endtask
	task automatic tend(input string name);
		$display("Test %s finished, mismatches so far %0d", name, miscompares);
	endtask
	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ==========================================
	// Watchdog
	initial begin
		repeat (60000) @(posedge CLK);
		miscompares++;
		$display("[FAIL] run length expected done seen timeout");
		print_verdict();
	end
	// ==========================================
	// Tests
	initial begin
		repeat (12) @(posedge CLK);
		SYS_RST <= 1'b0;
		rc("status after reset", `BCME_OFS_STAT, 32'h0, 1'b0);
		rc("unmapped read", 13'h0030, 32'h0, 1'b1);
		tend("reset");
		wr(ram(12'h100), 32'h000000A1);
		wr(ram(12'h104), 32'h000000B2);
		fill4(12'h200, 32'hFFFFFFFF);
		setp(16'h0100, 16'h0200, 12'h008, 12'h008);
		run(cw(`BCME_SVC_MOVE, 2'h0, 1'b0, 1'b0, 1'b0, 2'h0), `BCME_ST_OK);
		rc("move word0", ram(12'h200), 32'h000000A1, 1'b0);
		rc("move word1", ram(12'h204), 32'h000000B2, 1'b0);
		rc("move beyond", ram(12'h208), 32'hFFFFFFFF, 1'b0);
		tend("bulk move");
		setp(16'h0100, 16'h0200, 12'h008, 12'h010);
		for (int c = 0; c < 4; c++) begin
			for (int ci = 0; ci < 2; ci++) begin
				tk = (c == 0) || (c == 2 && ci == 1) || (c == 3 && ci == 0);
				fill4(12'h200, 32'hFFFFFFFF);
				run(cw(`BCME_SVC_COND, 2'(c), 1'(ci), 1'b0, 1'b0, 2'h0), `BCME_ST_OK);
				rc("cond word0", ram(12'h200), tk ? 32'h000000A1 : 32'hFFFFFFFF, 1'b0);
				rc("cond word1", ram(12'h204), tk ? 32'h000000B2 : 32'hFFFFFFFF, 1'b0);
				rc("cond word3", ram(12'h20C), tk ? 32'h00000000 : 32'hFFFFFFFF, 1'b0);
			end
		end
		tend("conditional copy");
		fill4(12'h200, 32'hFFFFFFFF);
		setp(16'h0000, 16'h0200, 12'h007, 12'h010);
		run(cw(`BCME_SVC_COND, `BCME_CND_ALWAYS, 1'b0, 1'b0, 1'b0, 2'h0), `BCME_ST_OK);
		for (int i = 0; i < 4; i++) rc("clear word", ram(12'h200 + 12'(4 * i)), 32'h0, 1'b0);
		setp(16'h0102, 16'h0200, 12'h008, 12'h010);
		run(cw(`BCME_SVC_COND, `BCME_CND_ALWAYS, 1'b0, 1'b0, 1'b0, 2'h0), `BCME_ST_BAD);
		tend("clear and refusal");
		wr(ram(12'h100), 32'h00000002);
		wr(ram(12'h104), 32'h00000001);
		fill4(12'h300, 32'h00000000);
		wr(ram(12'h300), 32'h00000001);
		setp(16'h0100, 16'h0200, 12'h008, 12'h00C);
		wr(`BCME_OFS_ACC, 32'h00000300);
		wr(`BCME_OFS_MUL, 32'h00000003);
		wr(`BCME_OFS_CAR, 32'h00000005);
		run(cw(`BCME_SVC_MUL, 2'h0, 1'b0, 1'b0, 1'b1, 2'h0), `BCME_ST_OK);
		rc("mac word0", ram(12'h200), 32'h0000000C, 1'b0);
		rc("mac word1", ram(12'h204), 32'h00000003, 1'b0);
		rc("mac word2", ram(12'h208), 32'h00000000, 1'b0);
		setp(16'h0100, 16'h0200, 12'h008, 12'h008);
		run(cw(`BCME_SVC_MUL, 2'h0, 1'b0, 1'b1, 1'b0, 2'h0), `BCME_ST_OK);
		rc("sub word0", ram(12'h200), 32'hFFFFFFF5, 1'b0);
		rc("sub word1", ram(12'h204), 32'hFFFFFFFC, 1'b0);
		rc("sub beyond", ram(12'h208), 32'h00000000, 1'b0);
		run(cw(`BCME_SVC_MUL, 2'h0, 1'b0, 1'b0, 1'b0, 2'h0) | 12'h200, `BCME_ST_OK);
		rc("gf mul word0", ram(12'h200), 32'h00000003, 1'b0);
		rc("gf mul word1", ram(12'h204), 32'h00000003, 1'b0);
		tend("small multiply");
		wr(ram(12'h400), 32'h00000007);
		wr(ram(12'h404), 32'h00000000);
		wr(`BCME_OFS_MODP, 32'h00000400);
		wr(`BCME_OFS_MODL, 32'h00000004);
		wr(`BCME_OFS_CNS, 32'h00000500);
		wr(ram(12'h600), 32'h0000000A);
		wr(ram(12'h604), 32'h00000000);
		setp(16'h0000, 16'h0600, 12'h004, 12'h008);
		run(cw(`BCME_SVC_MOD, 2'h0, 1'b0, 1'b0, 1'b0, `BCME_OP_NORM), `BCME_ST_NOSETUP);
		rc("unset norm", ram(12'h600), 32'h0000000A, 1'b0);
		run(cw(`BCME_SVC_MOD, 2'h0, 1'b0, 1'b0, 1'b0, `BCME_OP_CNS), `BCME_ST_OK);
		rc("setup flag", `BCME_OFS_STAT, 32'h00010000, 1'b0);
		run(cw(`BCME_SVC_MOD, 2'h0, 1'b0, 1'b0, 1'b0, `BCME_OP_NORM), `BCME_ST_OK);
		rc("norm word0", ram(12'h600), 32'h00000003, 1'b0);
		rc("norm quotient", ram(12'h608), 32'h00000001, 1'b0);
		wr(ram(12'h600), 32'h00000017);
		run(cw(`BCME_SVC_MOD, 2'h0, 1'b0, 1'b0, 1'b0, `BCME_OP_RED), `BCME_ST_OK);
		rc("red word0", ram(12'h600), 32'h00000002, 1'b0);
		rc("red word1", ram(12'h604), 32'h00000000, 1'b0);
		rc("red quo low", ram(12'h608), 32'h00000003, 1'b0);
		rc("red quo high", ram(12'h60C), 32'h00000000, 1'b0);
		wr(ram(12'h600), 32'h00000007);
		run(cw(`BCME_SVC_MOD, 2'h0, 1'b0, 1'b0, 1'b0, `BCME_OP_RED) | 12'h200, `BCME_ST_OK);
		rc("gf red word0", ram(12'h600), 32'h00000000, 1'b0);
		rc("gf red quo", ram(12'h608), 32'h00000001, 1'b0);
		setp(16'h0100, 16'h0600, 12'h004, 12'h008);
		run(cw(`BCME_SVC_MUL, 2'h0, 1'b0, 1'b0, 1'b0, 2'h0) | 12'h100, `BCME_ST_OK);
		rc("mod mul word0", ram(12'h600), 32'h00000004, 1'b0);
		rc("mod mul word1", ram(12'h604), 32'h00000000, 1'b0);
		rc("mod mul quo", ram(12'h608), 32'h00000001, 1'b0);
		tend("modular reduction");
		print_verdict();
	end
endmodule
`default_nettype wire
